// *** core/sws_consts.vh ***
// constants of the setpoint waveform sequencer
`ifndef SWS_CONSTS_VH
`define SWS_CONSTS_VH
// register word addresses
`define SWS_A_CTRL 8'h00
`define SWS_A_STAT 8'h01
`define SWS_A_AMPL 8'h02
`define SWS_A_OFFS 8'h03
`define SWS_A_T1 8'h04
`define SWS_A_T2 8'h05
`define SWS_A_T3 8'h06
`define SWS_A_T4 8'h07
`define SWS_A_ECYC 8'h08
`define SWS_A_EPAU 8'h09
`define SWS_A_IDLU 8'h0A
`define SWS_A_GLBI 8'h0B
`define SWS_A_GLBP 8'h0C
`define SWS_A_ACYC 8'h0D
`define SWS_A_AFST 8'h0E
`define SWS_A_ALST 8'h0F
`define SWS_A_ES 8'h10
`define SWS_A_EE 8'h11
`define SWS_A_ET 8'h12
`define SWS_A_ECOM 8'h13
`define SWS_A_ACS 8'h14
`define SWS_A_ACE 8'h15
`define SWS_A_DCS 8'h16
`define SWS_A_DCE 8'h17
`define SWS_A_FS 8'h18
`define SWS_A_FE 8'h19
`define SWS_A_ANG 8'h1A
`define SWS_A_PT 8'h1B
`define SWS_A_PCOM 8'h1C
// control and status fields
`define SWS_CTRL_RUN 0
`define SWS_CTRL_MODE 2:1
`define SWS_CTRL_TGT 3
`define SWS_STAT_ERR 1
`define SWS_MODE_RECT 2'h0
`define SWS_MODE_TRAP 2'h1
`define SWS_MODE_ENG 2'h2
`define SWS_MODE_ARB 2'h3
// ranges and reset values
`define SWS_T_MAX 29'h15752A00
`define SWS_RST_T 29'h0000000A
`define SWS_CYC_MAX 10'h3E7
`define SWS_PT_MAX 7'h63
`define SWS_ENG_LAST 3'h4
`define SWS_ANG_MAX 9'h167
`define SWS_F_MAX 14'h2710
// sweep ratio 9.3 per second, held in tenths against 0.1 ms ticks
`define SWS_DF_SCALE 17'h186A0
`define SWS_RATIO_X10 7'h5D
`define SWS_DA_TICKS 20'hF4240
`define SWS_FINC 32'h00068DB9
`define SWS_ANG_INC 32'h00B60B61
// timing: clock period and tick period in ns
`define SWS_CLK_NS 20
`define SWS_TICK_NS 100000
`endif

// *** core/sws_seq.v ***
// setpoint waveform sequencer: registers, timers and set value generation
`timescale 1ns/1ps
`include "sws_consts.vh"
// Function
// - rectangle: top for first, base for second time
// - base at foot; base plus amplitude within nominal
// - trapezoid: rise, top, fall, base in order
// - engine curve: voltage only, five linear ramps
// - engine curve repeats 0..999 times, 0 endless
// - pause between engine repetitions unless count one
// - idle voltage before and after engine curve
// - current and power fixed at global values
// - 99 arbitrary points, one shared target
// - arbitrary: DC ramp plus swept sine
// - both frequencies zero suppresses sine
// - sine starts at angle 0..359 degrees
// - frequency to 10 kHz, amplitude half nominal
// - reject frequency sweep below 9.3 per second
// - reject tiny amplitude change over long time
// - arbitrary block cycles 1..999, 0 endless
// - block runs first to last, 1..99
// - point time 0.1 ms to 36e6 ms
// - DC values between amplitude and nominal minus it
module sws_seq #(
  parameter TICK_CYC = `SWS_TICK_NS / `SWS_CLK_NS,
  parameter [15:0] NOM_U = 16'h8000,
  parameter [15:0] NOM_I = 16'h8000
) (
  // clock, reset, enable
  input wire clk_i,
  input wire resetn_i,
  input wire ce_i,
  input wire sync_clr_i,
  // register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // set values to the power stage
  output reg [15:0] set_u_o,
  output reg [15:0] set_i_o,
  output reg [15:0] set_p_o,
  output reg busy_o
);
  //--------------------------------------------------------------------
  // functions
  //--------------------------------------------------------------------
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_LOAD = 4'h2;
  localparam [3:0] S_WAVE = 4'h4;
  localparam [3:0] S_PAUSE = 4'h8;
  localparam integer TICK_M1 = TICK_CYC - 1;
  localparam [12:0] TICK_LAST = TICK_M1[12:0];

  // linear progression from s to e after el of t ticks
  function [15:0] interp;
    input [15:0] s;
    input [15:0] e;
    input [28:0] el;
    input [28:0] t;
    reg signed [17:0] d;
    reg signed [47:0] pr;
    reg signed [47:0] q;
    begin
      d = $signed({2'h0, e}) - $signed({2'h0, s});
      pr = d * $signed({1'b0, el});
      q = pr / $signed({19'h0, t});
      interp = s + q[15:0];
    end
  endfunction

  // quarter sine table, 17 points, full scale 7FFF
  function [15:0] qsin;
    input [4:0] i;
    begin
      case (i)
        5'h00: qsin = 16'h0000;
        5'h01: qsin = 16'h0C8C;
        5'h02: qsin = 16'h18F9;
        5'h03: qsin = 16'h2528;
        5'h04: qsin = 16'h30FB;
        5'h05: qsin = 16'h3C56;
        5'h06: qsin = 16'h471C;
        5'h07: qsin = 16'h5133;
        5'h08: qsin = 16'h5A82;
        5'h09: qsin = 16'h62F2;
        5'h0A: qsin = 16'h6A6D;
        5'h0B: qsin = 16'h70E2;
        5'h0C: qsin = 16'h7641;
        5'h0D: qsin = 16'h7A7C;
        5'h0E: qsin = 16'h7D89;
        5'h0F: qsin = 16'h7F62;
        default: qsin = 16'h7FFF;
      endcase
    end
  endfunction

  // in-range check of a point or phase time
  function tok;
    input [31:0] w;
    begin
      tok = (w != 32'h0) && (w <= {3'h0, `SWS_T_MAX});
    end
  endfunction

  //--------------------------------------------------------------------
  // configuration registers
  //--------------------------------------------------------------------
  reg [3:0] ctrl_ff;
  reg err_ff;
  reg [15:0] ampl_ff, offs_ff, idle_u_ff, glob_i_ff, glob_p_ff;
  reg [28:0] t1_ff, t2_ff, t3_ff, t4_ff, eng_pause_ff;
  reg [9:0] eng_cyc_ff, arb_cyc_ff;
  reg [6:0] arb_first_ff, arb_last_ff;
  reg [15:0] es_ff, ee_ff, acs_ff, ace_ff, dcs_ff, dce_ff;
  reg [28:0] et_ff, pt_ff;
  reg [13:0] fs_ff, fe_ff;
  reg [8:0] ang_ff;
  // point memories, written only by a checked commit
  reg [15:0] eng_s_m [0:4];
  reg [15:0] eng_e_m [0:4];
  reg [28:0] eng_t_m [0:4];
  reg [15:0] acs_m [0:98];
  reg [15:0] ace_m [0:98];
  reg [15:0] dcs_m [0:98];
  reg [15:0] dce_m [0:98];
  reg [13:0] fs_m [0:98];
  reg [13:0] fe_m [0:98];
  reg [8:0] ang_m [0:98];
  reg [28:0] pt_m [0:98];

  wire [1:0] mode = ctrl_ff[`SWS_CTRL_MODE];
  wire tgt_i = ctrl_ff[`SWS_CTRL_TGT];
  wire [15:0] nom = tgt_i ? NOM_I : NOM_U;
  wire w16 = (wdata_i[31:16] == 16'h0);
  wire [15:0] w = wdata_i[15:0];
  wire [6:0] pidx = wdata_i[6:0] - 7'h01;
  wire [13:0] df = (fe_ff > fs_ff) ? fe_ff - fs_ff : fs_ff - fe_ff;
  wire [15:0] da = (ace_ff > acs_ff) ? ace_ff - acs_ff : acs_ff - ace_ff;
  wire [30:0] df_lhs = df * `SWS_DF_SCALE;
  wire [35:0] df_rhs = pt_ff * `SWS_RATIO_X10;
  wire [35:0] da_lim = da * `SWS_DA_TICKS;
  reg wr_ok;
  reg [3:0] st_ff;

  // acceptance of the write on the bus this cycle
  always @* begin
    wr_ok = 1'b1;
    case (addr_i)
      `SWS_A_AMPL: wr_ok = w16 && (w <= nom - offs_ff);
      `SWS_A_OFFS: wr_ok = w16 && (w <= nom - ampl_ff);
      `SWS_A_T1, `SWS_A_T2, `SWS_A_T3, `SWS_A_T4, `SWS_A_EPAU,
      `SWS_A_ET, `SWS_A_PT: wr_ok = tok(wdata_i);
      `SWS_A_ECYC, `SWS_A_ACYC: wr_ok = (wdata_i <= {22'h0, `SWS_CYC_MAX});
      `SWS_A_AFST: wr_ok = (wdata_i != 32'h0) && (wdata_i <= {25'h0, arb_last_ff});
      `SWS_A_ALST: wr_ok = (wdata_i >= {25'h0, arb_first_ff}) &&
                           (wdata_i <= {25'h0, `SWS_PT_MAX});
      `SWS_A_IDLU, `SWS_A_ES, `SWS_A_EE: wr_ok = w16 && (w <= NOM_U);
      `SWS_A_GLBI: wr_ok = w16 && (w <= NOM_I);
      `SWS_A_GLBP: wr_ok = w16;
      `SWS_A_ACS, `SWS_A_ACE: wr_ok = w16 && (w <= {1'b0, nom[15:1]});
      `SWS_A_DCS, `SWS_A_DCE: wr_ok = w16 && (w <= nom);
      `SWS_A_FS, `SWS_A_FE: wr_ok = (wdata_i <= {18'h0, `SWS_F_MAX});
      `SWS_A_ANG: wr_ok = (wdata_i <= {23'h0, `SWS_ANG_MAX});
      `SWS_A_ECOM: wr_ok = (wdata_i <= {29'h0, `SWS_ENG_LAST});
      `SWS_A_PCOM: wr_ok = (wdata_i != 32'h0) && (wdata_i <= {25'h0, `SWS_PT_MAX}) &&
        (dcs_ff >= acs_ff) && (dcs_ff <= nom - acs_ff) &&
        (dce_ff >= ace_ff) && (dce_ff <= nom - ace_ff) &&
        ((df == 14'h0) || ({5'h0, df_lhs} >= df_rhs)) &&
        ((da == 16'h0) || ({7'h0, pt_ff} <= da_lim));
      `SWS_A_CTRL: wr_ok = (st_ff == S_IDLE) || (wdata_i[3:1] == ctrl_ff[3:1]);
      default: wr_ok = 1'b1;
    endcase
  end

  // register writes; a refused value leaves the old one in place
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_ff <= 4'h0;
      err_ff <= 1'b0;
      ampl_ff <= 16'h0000;
      offs_ff <= 16'h0000;
      idle_u_ff <= 16'h0000;
      glob_i_ff <= 16'h0000;
      glob_p_ff <= 16'h0000;
      t1_ff <= `SWS_RST_T;
      t2_ff <= `SWS_RST_T;
      t3_ff <= `SWS_RST_T;
      t4_ff <= `SWS_RST_T;
      eng_pause_ff <= `SWS_RST_T;
      eng_cyc_ff <= 10'h001;
      arb_cyc_ff <= 10'h001;
      arb_first_ff <= 7'h01;
      arb_last_ff <= 7'h01;
      es_ff <= 16'h0000;
      ee_ff <= 16'h0000;
      et_ff <= `SWS_RST_T;
      acs_ff <= 16'h0000;
      ace_ff <= 16'h0000;
      dcs_ff <= 16'h0000;
      dce_ff <= 16'h0000;
      fs_ff <= 14'h0000;
      fe_ff <= 14'h0000;
      ang_ff <= 9'h000;
      pt_ff <= `SWS_RST_T;
    end else if (ce_i) begin
      // set wins over clear on the same edge
      if (wr_i && !wr_ok)
        err_ff <= 1'b1;
      else if (wr_i && addr_i == `SWS_A_STAT && wdata_i[`SWS_STAT_ERR])
        err_ff <= 1'b0;
      if (wr_i && wr_ok) begin
        case (addr_i)
          `SWS_A_CTRL: ctrl_ff <= wdata_i[3:0];
          `SWS_A_AMPL: ampl_ff <= w;
          `SWS_A_OFFS: offs_ff <= w;
          `SWS_A_T1: t1_ff <= wdata_i[28:0];
          `SWS_A_T2: t2_ff <= wdata_i[28:0];
          `SWS_A_T3: t3_ff <= wdata_i[28:0];
          `SWS_A_T4: t4_ff <= wdata_i[28:0];
          `SWS_A_ECYC: eng_cyc_ff <= wdata_i[9:0];
          `SWS_A_EPAU: eng_pause_ff <= wdata_i[28:0];
          `SWS_A_IDLU: idle_u_ff <= w;
          `SWS_A_GLBI: glob_i_ff <= w;
          `SWS_A_GLBP: glob_p_ff <= w;
          `SWS_A_ACYC: arb_cyc_ff <= wdata_i[9:0];
          `SWS_A_AFST: arb_first_ff <= wdata_i[6:0];
          `SWS_A_ALST: arb_last_ff <= wdata_i[6:0];
          `SWS_A_ES: es_ff <= w;
          `SWS_A_EE: ee_ff <= w;
          `SWS_A_ET: et_ff <= wdata_i[28:0];
          `SWS_A_ACS: acs_ff <= w;
          `SWS_A_ACE: ace_ff <= w;
          `SWS_A_DCS: dcs_ff <= w;
          `SWS_A_DCE: dce_ff <= w;
          `SWS_A_FS: fs_ff <= wdata_i[13:0];
          `SWS_A_FE: fe_ff <= wdata_i[13:0];
          `SWS_A_ANG: ang_ff <= wdata_i[8:0];
          `SWS_A_PT: pt_ff <= wdata_i[28:0];
          default: ;
        endcase
      end
    end
  end

  // point memories have no reset; commits copy the staged fields
  always @(posedge clk_i) begin
    if (ce_i && wr_i && wr_ok && addr_i == `SWS_A_ECOM) begin
      eng_s_m[wdata_i[2:0]] <= es_ff;
      eng_e_m[wdata_i[2:0]] <= ee_ff;
      eng_t_m[wdata_i[2:0]] <= et_ff;
    end
    if (ce_i && wr_i && wr_ok && addr_i == `SWS_A_PCOM) begin
      acs_m[pidx] <= acs_ff;
      ace_m[pidx] <= ace_ff;
      dcs_m[pidx] <= dcs_ff;
      dce_m[pidx] <= dce_ff;
      fs_m[pidx] <= fs_ff;
      fe_m[pidx] <= fe_ff;
      ang_m[pidx] <= ang_ff;
      pt_m[pidx] <= pt_ff;
    end
  end

  //--------------------------------------------------------------------
  // time base and sequencer
  //--------------------------------------------------------------------
  reg [12:0] div_ff;
  reg tick_ff;
  reg [2:0] ph_ff;
  reg [6:0] pt_idx_ff;
  reg [9:0] cyc_ff;
  reg [28:0] el_ff, dur_ff;
  reg [15:0] cs_ff, ce_ff, cas_ff, cae_ff;
  reg [13:0] cfs_ff, cfe_ff;
  reg [31:0] acc_ff;
  wire start = wr_i && addr_i == `SWS_A_CTRL && wdata_i[`SWS_CTRL_RUN];
  wire stop = wr_i && addr_i == `SWS_A_CTRL && !wdata_i[`SWS_CTRL_RUN];
  wire done = tick_ff && (el_ff + 29'h1 >= dur_ff);
  wire [15:0] top = offs_ff + ampl_ff;
  wire [9:0] ncyc = (mode == `SWS_MODE_ENG) ? eng_cyc_ff : arb_cyc_ff;
  wire again = (ncyc == 10'h0) || (cyc_ff + 10'h1 < ncyc);
  wire [6:0] ai = pt_idx_ff - 7'h01;
  wire [15:0] fnow = interp({2'h0, cfs_ff}, {2'h0, cfe_ff}, el_ff, dur_ff);
  wire [47:0] inc = fnow * `SWS_FINC;

  // 0.1 ms tick shared by all phase and point timers
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_ff <= 13'h0000;
      tick_ff <= 1'b0;
    end else if (ce_i) begin
      tick_ff <= (div_ff == TICK_LAST);
      div_ff <= (div_ff == TICK_LAST) ? 13'h0000 : div_ff + 13'h0001;
    end
  end

  // sequence state machine
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= S_IDLE;
      ph_ff <= 3'h0;
      pt_idx_ff <= 7'h00;
      cyc_ff <= 10'h000;
      el_ff <= 29'h0;
      dur_ff <= `SWS_RST_T;
      cs_ff <= 16'h0000;
      ce_ff <= 16'h0000;
      cas_ff <= 16'h0000;
      cae_ff <= 16'h0000;
      cfs_ff <= 14'h0000;
      cfe_ff <= 14'h0000;
      acc_ff <= 32'h0;
    end else if (ce_i) begin
      if (sync_clr_i || stop) begin
        st_ff <= S_IDLE;
      end else begin
        case (st_ff)
          S_IDLE: begin
            if (start) begin
              st_ff <= S_LOAD;
              ph_ff <= 3'h0;
              cyc_ff <= 10'h000;
              pt_idx_ff <= (wdata_i[`SWS_CTRL_MODE] == `SWS_MODE_ARB) ?
                           arb_first_ff : 7'h00;
            end
          end
          S_LOAD: begin
            st_ff <= S_WAVE;
            el_ff <= 29'h0;
            cas_ff <= 16'h0000;
            cae_ff <= 16'h0000;
            cfs_ff <= 14'h0000;
            cfe_ff <= 14'h0000;
            case (mode)
              `SWS_MODE_RECT: begin
                cs_ff <= ph_ff[0] ? offs_ff : top;
                ce_ff <= ph_ff[0] ? offs_ff : top;
                dur_ff <= ph_ff[0] ? t2_ff : t1_ff;
              end
              `SWS_MODE_TRAP: begin
                cs_ff <= (ph_ff == 3'h0 || ph_ff == 3'h3) ? offs_ff : top;
                ce_ff <= (ph_ff == 3'h2 || ph_ff == 3'h3) ? offs_ff : top;
                dur_ff <= (ph_ff == 3'h0) ? t1_ff : (ph_ff == 3'h1) ? t2_ff :
                          (ph_ff == 3'h2) ? t3_ff : t4_ff;
              end
              `SWS_MODE_ENG: begin
                cs_ff <= eng_s_m[pt_idx_ff[2:0]];
                ce_ff <= eng_e_m[pt_idx_ff[2:0]];
                dur_ff <= eng_t_m[pt_idx_ff[2:0]];
              end
              default: begin
                cs_ff <= dcs_m[ai];
                ce_ff <= dce_m[ai];
                cas_ff <= acs_m[ai];
                cae_ff <= ace_m[ai];
                cfs_ff <= fs_m[ai];
                cfe_ff <= fe_m[ai];
                dur_ff <= pt_m[ai];
                acc_ff <= ang_m[ai] * `SWS_ANG_INC;
              end
            endcase
          end
          S_WAVE: begin
            if (tick_ff) begin
              el_ff <= el_ff + 29'h1;
              acc_ff <= acc_ff + inc[31:0];
            end
            if (done) begin
              st_ff <= S_LOAD;
              case (mode)
                `SWS_MODE_RECT: ph_ff <= {2'h0, ~ph_ff[0]};
                `SWS_MODE_TRAP: ph_ff <= {1'b0, ph_ff[1:0] + 2'h1};
                `SWS_MODE_ENG: begin
                  if (pt_idx_ff[2:0] != `SWS_ENG_LAST) begin
                    pt_idx_ff <= pt_idx_ff + 7'h01;
                  end else if (again) begin
                    st_ff <= S_PAUSE;
                    el_ff <= 29'h0;
                    dur_ff <= eng_pause_ff;
                    pt_idx_ff <= 7'h00;
                    cyc_ff <= (ncyc == 10'h0) ? cyc_ff : cyc_ff + 10'h1;
                  end else begin
                    st_ff <= S_IDLE;
                  end
                end
                default: begin
                  if (pt_idx_ff != arb_last_ff) begin
                    pt_idx_ff <= pt_idx_ff + 7'h01;
                  end else if (again) begin
                    pt_idx_ff <= arb_first_ff;
                    cyc_ff <= (ncyc == 10'h0) ? cyc_ff : cyc_ff + 10'h1;
                  end else begin
                    st_ff <= S_IDLE;
                  end
                end
              endcase
            end
          end
          S_PAUSE: begin
            if (tick_ff)
              el_ff <= el_ff + 29'h1;
            if (done)
              st_ff <= S_LOAD;
          end
          default: st_ff <= S_IDLE;
        endcase
      end
    end
  end

  //--------------------------------------------------------------------
  // set value generation
  //--------------------------------------------------------------------
  wire [15:0] dc = interp(cs_ff, ce_ff, el_ff, dur_ff);
  wire [15:0] aamp = interp(cas_ff, cae_ff, el_ff, dur_ff);
  wire [1:0] quad = acc_ff[31:30];
  wire [4:0] qi = quad[0] ? 5'h10 - {1'b0, acc_ff[29:26]} : {1'b0, acc_ff[29:26]};
  wire [15:0] smag = qsin(qi);
  wire signed [16:0] sv = quad[1] ? -$signed({1'b0, smag}) : $signed({1'b0, smag});
  wire signed [33:0] acp = $signed({1'b0, aamp}) * sv;
  wire sine_on = (cfs_ff != 14'h0) || (cfe_ff != 14'h0);
  wire [15:0] wave = sine_on ? dc + acp[30:15] : dc;

  // voltage and current outputs are held while a new phase is loaded
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      set_u_o <= 16'h0000;
      set_i_o <= 16'h0000;
      set_p_o <= 16'h0000;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= (st_ff != S_IDLE);
      set_p_o <= glob_p_ff;
      if (st_ff == S_WAVE && (mode == `SWS_MODE_ENG || !tgt_i)) begin
        set_u_o <= wave;
        set_i_o <= glob_i_ff;
      end else if (st_ff == S_WAVE) begin
        set_u_o <= idle_u_ff;
        set_i_o <= wave;
      end else if (st_ff != S_LOAD) begin
        set_u_o <= idle_u_ff;
        set_i_o <= glob_i_ff;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h0;
    end else if (ce_i) begin
      rdata_o <= 32'h0;
      if (rd_i) begin
        case (addr_i)
          `SWS_A_CTRL: rdata_o <= {28'h0, ctrl_ff};
          `SWS_A_STAT: rdata_o <= {2'h0, cyc_ff, 1'b0, ph_ff, 1'b0, pt_idx_ff,
                                   6'h0, err_ff, busy_o};
          `SWS_A_AMPL: rdata_o <= {16'h0, ampl_ff};
          `SWS_A_OFFS: rdata_o <= {16'h0, offs_ff};
          `SWS_A_T1: rdata_o <= {3'h0, t1_ff};
          `SWS_A_T2: rdata_o <= {3'h0, t2_ff};
          `SWS_A_ECYC: rdata_o <= {22'h0, eng_cyc_ff};
          `SWS_A_ACYC: rdata_o <= {22'h0, arb_cyc_ff};
          `SWS_A_AFST: rdata_o <= {25'h0, arb_first_ff};
          `SWS_A_ALST: rdata_o <= {25'h0, arb_last_ff};
          default: rdata_o <= 32'h0;
        endcase
      end
    end
  end
endmodule // sws_seq

// *** testbench/sws_monitor.sv ***
// checker watching the sequencer top-level ports
`timescale 1ns/1ps
module sws_monitor (
  // clock and control
  input wire clk_i,
  input wire resetn_i,
  input wire ce_i,
  input wire sync_clr_i,
  // register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  // set values
  input wire [15:0] set_u_o,
  input wire [15:0] set_i_o,
  input wire [15:0] set_p_o,
  input wire busy_o
);
  // control word writes, shared by the run properties
  wire ctl_wr = ce_i && wr_i && addr_i == 8'h00 && !sync_clr_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_rdata_idle: assert property (ce_i && !rd_i |=> rdata_o == 32'h0)
    else $error("read data not cleared");
  a_unmapped_read: assert property (ce_i && rd_i && (addr_i > 8'h1C || addr_i == 8'h0A)
    |=> rdata_o == 32'h0) else $error("unreadable address gave data");
  a_run_start: assert property (ctl_wr && wdata_i[0] && !busy_o |-> ##2 busy_o)
    else $error("busy not raised after start");
  a_run_stop: assert property (ctl_wr && !wdata_i[0] |-> ##2 !busy_o)
    else $error("busy not dropped after stop");
  a_sync_idle: assert property (ce_i && sync_clr_i |-> ##2 !busy_o)
    else $error("clear did not reach idle");
  a_freeze_hold: assert property (!ce_i |=> $stable(set_u_o) && $stable(set_i_o)
    && $stable(busy_o)) else $error("outputs moved while frozen");
  a_power_global: assert property ($changed(set_p_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("power set value moved without a write");
  a_busy_refuse: assert property (ctl_wr && wdata_i[0] && busy_o |=> busy_o [*2])
    else $error("start while busy disturbed the run");
endmodule // sws_monitor

bind sws_seq sws_monitor u_mon (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
  .sync_clr_i(sync_clr_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .set_u_o(set_u_o), .set_i_o(set_i_o), .set_p_o(set_p_o), .busy_o(busy_o));

// *** testbench/sws_stage_model.sv ***
// power stage model taking the voltage set value
`timescale 1ns/1ps
module sws_stage_model #(
  parameter logic [15:0] NOM = 16'h8000
) (
  // stage clock and set value input
  input wire logic clk_i,
  input wire logic [15:0] set_u_i,
  // sticky flag: a set value above nominal was ever latched
  output logic over_o
);
  // latch like the stage input; sticky so a one-cycle overshoot is not lost
  initial over_o = 1'b0;
  always @(posedge clk_i) begin
    over_o <= over_o | (set_u_i > NOM);
  end
endmodule // sws_stage_model

// *** testbench/testbench.sv ***
// self-checking bench for the setpoint waveform sequencer
`timescale 1ns/1ps
module testbench;
  localparam int NOM = 32768;
  localparam int TK = 4;
  localparam logic [7:0] RA [11] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h0D,
    8'h0E, 8'h0F, 8'h0A, 8'h3C};
  logic clk_i = 0, resetn_i = 0, ce_i = 1, sync_clr_i = 0, wr_i = 0, rd_i = 0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  wire [31:0] rdata_o;
  wire [15:0] set_u_o, set_i_o, set_p_o;
  wire busy_o, over;
  int errors = 0, checks_done = 0;
  int m [0:31];
  bit err_m, mid, top_seen;
  logic [15:0] q [$], e [$], top, hold_v;
  int ampl, offs, gi, n, i;

  sws_seq #(.TICK_CYC(TK)) dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .sync_clr_i(sync_clr_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .set_u_o(set_u_o), .set_i_o(set_i_o), .set_p_o(set_p_o),
    .busy_o(busy_o));
  sws_stage_model u_stage (.clk_i(clk_i), .set_u_i(set_u_o), .over_o(over));

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // write; the model decides acceptance from the ranges before the bus cycle
  task automatic wr(input logic [7:0] a, input int v);
    bit ok;
    longint df, da, t;
    ok = 1;
    df = m[25] - m[24];
    da = m[21] - m[20];
    t = m[27];
    case (a)
      8'h00: ok = !(busy_o === 1'b1 && v[3:1] != m[0][3:1]);
      8'h01: if (v[1]) err_m = 0;
      8'h02: ok = v <= NOM - m[3];
      8'h03: ok = v <= NOM - m[2];
      8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h12, 8'h1B: ok = v >= 1 && v <= 360000000;
      8'h08, 8'h0D: ok = v <= 999;
      8'h0A, 8'h0B, 8'h0C, 8'h10, 8'h11: ok = v <= NOM;
      8'h0E: ok = v >= 1 && v <= m[15];
      8'h0F: ok = v >= m[14] && v <= 99;
      8'h13: ok = v <= 4;
      8'h14, 8'h15: ok = v <= NOM / 2;
      8'h18, 8'h19: ok = v <= 10000;
      8'h1A: ok = v <= 359;
      8'h1C: ok = v >= 1 && v <= 99 && m[22] >= m[20] && m[22] <= NOM - m[20]
        && m[23] >= m[21] && m[23] <= NOM - m[21]
        && (df == 0 || (df < 0 ? -df : df) * 100000 >= 93 * t)
        && (da == 0 || t <= (da < 0 ? -da : da) * 1000000);
      default: ;
    endcase
    if (!ok) err_m = 1;
    else if (a < 8'h1D && a != 8'h01) m[a[4:0]] = v;
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1;
    @(posedge clk_i);
    wr_i <= 0;
  endtask

  // read and compare; status is judged on its error bit only
  task automatic rdc(input logic [7:0] a);
    logic [31:0] x;
    x = 0;
    if (a inside {8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h0D, 8'h0E, 8'h0F}) x = m[a[4:0]];
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge clk_i);
    rd_i <= 0;
    #1;
    if (a == 8'h01) chk(32'(rdata_o[1]), 32'(err_m));
    else chk(rdata_o, x);
  endtask

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  // count cycles that the voltage holds v, bounded
  task automatic hold(input logic [15:0] v, output int c);
    c = 0;
    while (set_u_o === v && c < 200) begin
      step();
      c++;
    end
  endtask

  // record voltage changes until a finite run ends; current must stay global
  task automatic watch(input int lim);
    bit seen;
    logic [15:0] last;
    q.delete();
    last = set_u_o;
    seen = 0;
    for (n = 0; n < lim && !(seen && busy_o === 1'b0); n++) begin
      step();
      if (busy_o === 1'b1) seen = 1;
      if (set_u_o !== last) q.push_back(set_u_o);
      last = set_u_o;
      chk(set_i_o, gi[15:0]);
    end
    if (n >= lim) begin
      errors++;
      $display("mismatch t=%0t run did not end", $time);
      final_report();
    end
    chk(q.size(), e.size());
    foreach (e[k]) if (k < q.size()) chk(q[k], e[k]);
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk_i);
    errors++;
    $display("mismatch t=%0t run too long", $time);
    final_report();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h85A2F32E));
    m = '{default: 0};
    for (i = 4; i < 8; i++) m[i] = 10;
    m[9] = 10;
    m[18] = 10;
    m[27] = 10;
    m[8] = 1;
    m[13] = 1;
    m[14] = 1;
    m[15] = 1;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1;
    foreach (RA[k]) rdc(RA[k]);
    chk(busy_o, 0);
    // range refusals keep the old value and raise the error flag
    wr(8'h02, NOM + 1);
    wr(8'h04, 0);
    wr(8'h05, 360000001);
    wr(8'h0F, 100);
    wr(8'h0E, 2);
    wr(8'h0D, 1000);
    foreach (RA[k]) rdc(RA[k]);
    rdc(8'h01);
    wr(8'h01, 2);
    rdc(8'h01);
    // rectangle with random levels
    ampl = $urandom_range(16383, 2);
    offs = $urandom_range(16383, 0);
    gi = $urandom_range(NOM, 0);
    top = 16'(ampl + offs);
    wr(8'h02, ampl);
    wr(8'h03, offs);
    wr(8'h0B, gi);
    wr(8'h0C, $urandom_range(NOM, 0));
    wr(8'h0A, 300);
    wr(8'h04, 2);
    wr(8'h05, 3);
    wr(8'h00, 1);
    for (n = 0; n < 20 && set_u_o !== top; n++) step();
    chk(set_u_o, top);
    chk(set_p_o, m[12]);
    hold(top, n);
    chk(32'(n >= TK && n <= 2 * TK + 2), 1);
    chk(set_u_o, 16'(offs));
    hold(16'(offs), n);
    chk(32'(n >= 2 * TK && n <= 3 * TK + 2), 1);
    // freeze mid-run: nothing moves while the enable is low
    @(posedge clk_i);
    ce_i <= 0;
    #1;
    hold_v = set_u_o;
    repeat (11) step();
    @(posedge clk_i);
    ce_i <= 1;
    #1;
    chk(set_u_o, hold_v);
    wr(8'h00, 7);
    rdc(8'h01);
    chk(busy_o, 1);
    wr(8'h01, 2);
    wr(8'h00, 0);
    repeat (3) step();
    chk(busy_o, 0);
    chk(set_u_o, 300);
    // trapezoid: a slope value must come before the top
    wr(8'h06, 2);
    wr(8'h07, 2);
    wr(8'h00, 3);
    mid = 0;
    top_seen = 0;
    repeat (80) begin
      step();
      if (set_u_o === 16'(offs + ampl / 2) && !top_seen) mid = 1;
      if (set_u_o === top) top_seen = 1;
    end
    chk(32'({mid, top_seen}), 3);
    @(posedge clk_i);
    sync_clr_i <= 1;
    @(posedge clk_i);
    sync_clr_i <= 0;
    repeat (2) step();
    chk(busy_o, 0);
    // engine curve: five points, two passes, pause at idle voltage
    e.delete();
    for (i = 0; i < 5; i++) begin
      wr(8'h10, 1000 * (i + 1));
      wr(8'h11, 1000 * (i + 1));
      wr(8'h12, 2);
      wr(8'h13, i);
    end
    for (i = 0; i < 12; i++) e.push_back(i % 6 == 5 ? 16'd300 : 16'(1000 * (i % 6 + 1)));
    wr(8'h08, 2);
    wr(8'h09, 3);
    wr(8'h00, 5);
    watch(600);
    // arbitrary block of two plain DC points
    wr(8'h1B, 2);
    wr(8'h16, 700);
    wr(8'h17, 700);
    wr(8'h1C, 1);
    wr(8'h16, 900);
    wr(8'h17, 900);
    wr(8'h1C, 2);
    wr(8'h0F, 2);
    e = '{16'd700, 16'd900, 16'd300};
    wr(8'h00, 7);
    watch(300);
    // plausibility refusals on point commit, then range refusals of point fields
    wr(8'h18, 1);
    wr(8'h19, 11);
    wr(8'h1B, 50000);
    wr(8'h1C, 3);
    rdc(8'h01);
    wr(8'h01, 2);
    wr(8'h1B, 10000);
    wr(8'h1C, 3);
    rdc(8'h01);
    wr(8'h18, 0);
    wr(8'h19, 0);
    wr(8'h14, 100);
    wr(8'h15, 101);
    wr(8'h1B, 2000000);
    wr(8'h1C, 4);
    rdc(8'h01);
    wr(8'h01, 2);
    wr(8'h1B, 10);
    wr(8'h16, 50);
    wr(8'h1C, 5);
    wr(8'h14, NOM / 2 + 1);
    wr(8'h1A, 360);
    wr(8'h19, 10001);
    rdc(8'h01);
    chk(over, 0);
    final_report();
  end
endmodule // testbench
